// ===== rtl/aehl_axis.sv
// four-axis encoder, limit and home logic with an AXI4-Lite register slave
// Operation
// - limit active kills drive on that axis only
// - limit polarity chosen per axis
// - home seek stops axis on home switch
// - home found loads counter with operand
// - home sense invertable per axis
// - count quadrature edges up to 4 MHz
// - times-four decode, every edge counts
// - switch homing: load, then ramp or stop
// - homing direction, level, response configurable
// - index homing: index, low switch, quadrant
// - index homing ignores home sense inversion
// - phase invert or swap reverses count
// - servo axes drive from filtered error
// - stepper axes correct error after move
// - slip detection selectable in every mode
// - armed slip sets encoder error flag
// - overtravel sets overtravel flag
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`default_nettype none
module aehl_axis
  import aehl_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // encoder, limit and home inputs, one bit per axis
  input  wire logic [3:0]  enc_a,
  input  wire logic [3:0]  enc_b,
  input  wire logic [3:0]  enc_idx,
  input  wire logic [3:0]  limit_in,
  input  wire logic [3:0]  home_sw,
  input  wire logic [3:0]  move_done,
  // drive side
  output logic [3:0]       drive_en,
  output logic [3:0]       seek_run,
  output logic [3:0]       seek_dir,
  output logic [3:0]       decel_req,
  output logic [3:0]       stop_now,
  output logic [3:0]       corr_req,
  output logic [3:0]       corr_dir,
  output logic [63:0]      servo_out
);

  function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++)
      if (s[k]) r[8*k +: 8] = d[8*k +: 8];
    return r;
  endfunction

  // +1 when A leads B, -1 when B leads A, 0 for no or illegal change
  function automatic logic [1:0] qstep(input logic [1:0] p, input logic [1:0] c);
    logic [1:0] r;
    r = 2'h0;
    case ({p, c})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: r = 2'h1;
      4'b0001, 4'b0111, 4'b1110, 4'b1000: r = 2'h3;
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] mag(input logic [31:0] v);
    return v[31] ? 32'(-v) : v;
  endfunction

  // 0x1C is the one hole below the top of the map
  function automatic logic amap(input logic [7:0] a);
    return (a[7:4] <= OFS_ERR[7:4]) && !(a[7:4] == OFS_STAT[7:4] && a[3:2] == 2'h3);
  endfunction

  function automatic logic [15:0] sat16(input logic [39:0] v);
    if (!v[39] && v[38:15] != 24'h0) return 16'h7FFF;
    if (v[39] && v[38:15] != 24'hFF_FFFF) return 16'h8000;
    return v[15:0];
  endfunction

  // bus slave and registers
  logic        aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bvalid_r, bvalid_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] cfg_r, cfg_nxt, enc_r, enc_nxt, hval_r, hval_nxt, slip_r, slip_nxt;
  logic [7:0]  gain_r, gain_nxt;
  logic [3:0]  overtravel_flag_r, overtravel_flag_nxt, slipf_r, slipf_nxt, cmd_seek, cmd_rev, cmd_abort;
  logic [31:0] tgt_r [NAX];
  logic [31:0] tgt_nxt [NAX];
  logic        wr_fire;
  logic [3:0]  wr_grp, rd_grp;
  logic        wr_hit, rd_hit;
  // axis state
  aehl_home_st_t hs_r [NAX];
  aehl_home_st_t hs_nxt [NAX];
  logic [31:0] cnt_r [NAX];
  logic [31:0] cnt_nxt [NAX];
  logic [31:0] err [NAX];
  logic [1:0]  ab_r [NAX];
  logic [1:0]  ab_nxt [NAX];
  logic [1:0]  ab_cur [NAX];
  logic [1:0]  qs [NAX];
  logic [3:0]  dir_r, dir_nxt, lim_act, home_hit, slip_over;
  logic [3:0]  decel_nxt, stop_nxt, corr_nxt, cdir_nxt, decel_r, stop_r, corr_r, cdir_r;
  logic [63:0] servo_nxt, servo_r;

  assign wr_fire       = aw_ok_r && w_ok_r && !bvalid_r;
  assign wr_grp        = awaddr_r[7:4];
  assign rd_grp        = s_axi_araddr[7:4];
  assign s_axi_awready = !aw_ok_r && !bvalid_r;
  assign s_axi_wready  = !w_ok_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // address and data taken in either order, answer once both are in
  always_comb
  begin
    aw_ok_nxt  = aw_ok_r;
    w_ok_nxt   = w_ok_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wstrb_nxt  = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    wr_hit = amap(awaddr_r);
    rd_hit = amap(s_axi_araddr);
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_ok_nxt  = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_ok_nxt  = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      aw_ok_nxt  = 1'b0;
      w_ok_nxt   = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = wr_hit ? RESP_OK : RESP_DEC;
    end
    else if (bvalid_r && s_axi_bready)
      bvalid_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = rd_hit ? RESP_OK : RESP_DEC;
      rdata_nxt  = 32'h0;
      case (s_axi_araddr)
        OFS_CFG:  rdata_nxt = cfg_r;
        OFS_ENC:  rdata_nxt = enc_r;
        OFS_HVAL: rdata_nxt = hval_r;
        OFS_STAT: rdata_nxt = {16'h0, drive_en, seek_run, slipf_r, overtravel_flag_r};
        OFS_SLIP: rdata_nxt = slip_r;
        OFS_GAIN: rdata_nxt = {24'h0, gain_r};
        default:
        begin
          if (rd_grp == OFS_POS[7:4]) rdata_nxt = cnt_r[s_axi_araddr[3:2]];
          if (rd_grp == OFS_TGT[7:4]) rdata_nxt = tgt_r[s_axi_araddr[3:2]];
          if (rd_grp == OFS_ERR[7:4]) rdata_nxt = err[s_axi_araddr[3:2]];
        end
      endcase
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
  end

  // software-written settings; status flags are set by hardware, cleared by writing one
  always_comb
  begin
    cfg_nxt   = cfg_r;
    enc_nxt   = enc_r;
    hval_nxt  = hval_r;
    slip_nxt  = slip_r;
    gain_nxt  = gain_r;
    tgt_nxt   = tgt_r;
    overtravel_flag_nxt  = overtravel_flag_r;
    slipf_nxt = slipf_r;
    cmd_seek  = 4'h0;
    cmd_rev   = 4'h0;
    cmd_abort = 4'h0;
    if (wr_fire)
    begin
      case (awaddr_r)
        OFS_CFG:  cfg_nxt  = wmask(cfg_r, wdata_r, wstrb_r);
        OFS_ENC:  enc_nxt  = wmask(enc_r, wdata_r, wstrb_r);
        OFS_HVAL: hval_nxt = wmask(hval_r, wdata_r, wstrb_r);
        OFS_SLIP: slip_nxt = wmask(slip_r, wdata_r, wstrb_r);
        OFS_GAIN: gain_nxt = wstrb_r[0] ? wdata_r[7:0] : gain_r;
        OFS_CMD:
        begin
          cmd_seek  = wstrb_r[0] ? wdata_r[CM_SEEK +: NAX] : 4'h0;
          cmd_rev   = wstrb_r[0] ? wdata_r[CM_REV +: NAX] : 4'h0;
          cmd_abort = wstrb_r[1] ? wdata_r[CM_ABORT +: NAX] : 4'h0;
        end
        OFS_STAT:
        begin
          overtravel_flag_nxt  = overtravel_flag_r & ~(wstrb_r[0] ? wdata_r[ST_OVERTRAVEL_FLAG +: NAX] : 4'h0);
          slipf_nxt = slipf_r & ~(wstrb_r[0] ? wdata_r[ST_SLIP +: NAX] : 4'h0);
        end
        default:
          if (wr_grp == OFS_TGT[7:4])
            tgt_nxt[awaddr_r[3:2]] = wmask(tgt_r[awaddr_r[3:2]], wdata_r, wstrb_r);
      endcase
    end
    // a set arriving with its clear wins
    overtravel_flag_nxt  = overtravel_flag_nxt | lim_act;
    slipf_nxt = slipf_nxt | (slip_over & cfg_r[CF_SLIP +: NAX]);
  end

  // per-axis decode, homing and error use
  always_comb
  begin
    hs_nxt    = hs_r;
    cnt_nxt   = cnt_r;
    ab_nxt    = ab_r;
    dir_nxt   = dir_r;
    decel_nxt = 4'h0;
    stop_nxt  = 4'h0;
    corr_nxt  = 4'h0;
    cdir_nxt  = cdir_r;
    servo_nxt = 64'h0;
    for (int i = 0; i < NAX; i++)
    begin
      // invert or swap phases to reverse the count; only inverting A moves the home quadrant
      ab_cur[i]  = enc_r[EN_SWAP + i] ? {enc_b[i], enc_a[i] ^ enc_r[EN_AINV + i]}
                                      : {enc_a[i] ^ enc_r[EN_AINV + i], enc_b[i]};
      lim_act[i] = limit_in[i] ~^ cfg_r[CF_LIMH + i];
      // index mode ignores sense inversion: switch low-true only
      home_hit[i] = cfg_r[CF_HIDX + i] ? (enc_idx[i] && !home_sw[i] && ab_cur[i] == 2'b11)
                                       : (home_sw[i] ~^ cfg_r[CF_HSINV + i]);
      err[i]       = 32'(tgt_r[i] - cnt_r[i]);
      slip_over[i] = mag(err[i]) > slip_r;
      ab_nxt[i]    = ab_cur[i];
      // sampled every clock, far above the edge rate needed
      qs[i]      = qstep(ab_r[i], ab_cur[i]);
      cnt_nxt[i] = 32'(cnt_r[i] + {{30{qs[i][1]}}, qs[i]});
      case (hs_r[i])
        HS_IDLE:
          if ((cmd_seek[i] || cmd_rev[i]) && !lim_act[i])
          begin
            hs_nxt[i]  = HS_SEEK;
            dir_nxt[i] = !cmd_rev[i];
          end
        HS_SEEK:
          if (lim_act[i] || cmd_abort[i])
            hs_nxt[i] = HS_IDLE;
          else if (home_hit[i])
          begin
            hs_nxt[i]  = HS_HALT;
            cnt_nxt[i] = hval_r;
            if (cfg_r[CF_HSTOP + i])
              stop_nxt[i] = 1'b1;
            else
              decel_nxt[i] = 1'b1;
          end
        HS_HALT:
          hs_nxt[i] = HS_IDLE;
        default:
          hs_nxt[i] = HS_IDLE;
      endcase
      // stepper correction once the move is over
      if (cfg_r[CF_STEP + i] && move_done[i] && err[i] != 32'h0 && !lim_act[i])
      begin
        corr_nxt[i] = 1'b1;
        cdir_nxt[i] = !err[i][31];
      end
      // servo: proportional filter, zero drive while limit removes excitation
      if (!cfg_r[CF_STEP + i] && !lim_act[i])
        servo_nxt[16*i +: 16] =
          sat16(40'(($signed(err[i]) * $signed({1'b0, gain_r})) >>> 4));
    end
  end

  assign drive_en  = ~lim_act;
  assign decel_req = decel_r;
  assign stop_now  = stop_r;
  assign corr_req  = corr_r;
  assign corr_dir  = cdir_r;
  assign servo_out = servo_r;
  assign seek_dir  = dir_r;
  always_comb
    for (int i = 0; i < NAX; i++)
      seek_run[i] = (hs_r[i] == HS_SEEK);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ok_r <= 1'b0;  w_ok_r <= 1'b0;  bvalid_r <= 1'b0;  rvalid_r <= 1'b0;
      awaddr_r <= 8'h0;  wdata_r <= 32'h0;  wstrb_r <= 4'h0;  rdata_r <= 32'h0;
      bresp_r <= RESP_OK;  rresp_r <= RESP_OK;
      cfg_r <= CFG_RST;  enc_r <= ENC_RST;  hval_r <= HVAL_RST;  slip_r <= SLIP_RST;
      gain_r <= GAIN_RST;  overtravel_flag_r <= 4'h0;  slipf_r <= 4'h0;  dir_r <= 4'h0;
      decel_r <= 4'h0;  stop_r <= 4'h0;  corr_r <= 4'h0;  cdir_r <= 4'h0;
      servo_r <= 64'h0;
      for (int i = 0; i < NAX; i++)
      begin
        tgt_r[i] <= 32'h0;  cnt_r[i] <= 32'h0;  ab_r[i] <= 2'h0;  hs_r[i] <= HS_IDLE;
      end
    end
    else
    begin
      aw_ok_r <= aw_ok_nxt;  w_ok_r <= w_ok_nxt;  bvalid_r <= bvalid_nxt;
      rvalid_r <= rvalid_nxt;  awaddr_r <= awaddr_nxt;  wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;  rdata_r <= rdata_nxt;  bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;  cfg_r <= cfg_nxt;  enc_r <= enc_nxt;  hval_r <= hval_nxt;
      slip_r <= slip_nxt;  gain_r <= gain_nxt;  overtravel_flag_r <= overtravel_flag_nxt;  slipf_r <= slipf_nxt;
      dir_r <= dir_nxt;  decel_r <= decel_nxt;  stop_r <= stop_nxt;  corr_r <= corr_nxt;
      cdir_r <= cdir_nxt;  servo_r <= servo_nxt;  tgt_r <= tgt_nxt;  cnt_r <= cnt_nxt;
      ab_r <= ab_nxt;  hs_r <= hs_nxt;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_seek_hit;
    hs_r[2] == HS_SEEK && home_hit[2] && !lim_act[2] && !cmd_abort[2];
  endsequence

  a_limit_one_axis: assert property ((limit_in[1] ~^ cfg_r[CF_LIMH + 1]) &&
    !(limit_in[0] ~^ cfg_r[CF_LIMH]) |-> !drive_en[1] && drive_en[0])
    else $error("limit did not act on its own axis only");
  a_home_load: assert property (s_seek_hit |=> cnt_r[2] == $past(hval_r))
    else $error("home did not load operand");
  a_home_halt: assert property (s_seek_hit |=>
    !seek_run[2] ##0 (decel_req[2] ^ stop_now[2]) ##1 !decel_req[2] && !stop_now[2])
    else $error("home seek did not halt with one pulse");
  a_stop_mode: assert property (s_seek_hit ##0 cfg_r[CF_HSTOP + 2] |=> stop_now[2])
    else $error("immediate stop not taken");
  a_idx_gate: assert property (hs_r[3] == HS_SEEK && cfg_r[CF_HIDX + 3] && !lim_act[3] &&
    !(enc_idx[3] && !home_sw[3] && ab_cur[3] == 2'b11) |=> !decel_req[3] && !stop_now[3])
    else $error("index home qualified wrongly");
  a_cnt_step: assert property (hs_r[0] != HS_SEEK |=>
    mag(32'(cnt_r[0] - $past(cnt_r[0]))) <= 32'h1)
    else $error("count moved by more than one");
  a_overtravel_flag_flag: assert property (lim_act[1] |=>
    overtravel_flag_r[1] ##1 (overtravel_flag_r[1] || !$past(lim_act[1])))
    else $error("overtravel flag not set");
  a_slip_flag: assert property (slip_over[0] && cfg_r[CF_SLIP] |=> slipf_r[0])
    else $error("slip flag not set");
  a_corr_pulse: assert property (cfg_r[CF_STEP] && move_done[0] && err[0] != 32'h0 &&
    !lim_act[0] |=> corr_req[0] && corr_dir[0] == !$past(err[0][31]))
    else $error("stepper correction missing");
  a_write_answer: assert property (wr_fire |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
    else $error("write answer late");

endmodule // aehl_axis
`default_nettype wire

// ===== rtl/aehl_pkg.sv
// constants and types for the axis encoder, home and limit block
`default_nettype none
package aehl_pkg;
  localparam int NAX         = 4;
  localparam int CLK_HZ      = 25_000_000;
  localparam int ENC_MAX_HZ  = 4_000_000;
  localparam int ENC_MIN_CYC = (CLK_HZ + ENC_MAX_HZ - 1) / ENC_MAX_HZ;
  // register byte offsets; count, target and error groups step 4 per axis
  localparam logic [7:0] OFS_CFG  = 8'h00;
  localparam logic [7:0] OFS_ENC  = 8'h04;
  localparam logic [7:0] OFS_CMD  = 8'h08;
  localparam logic [7:0] OFS_HVAL = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_SLIP = 8'h14;
  localparam logic [7:0] OFS_GAIN = 8'h18;
  localparam logic [7:0] OFS_POS  = 8'h20;
  localparam logic [7:0] OFS_TGT  = 8'h30;
  localparam logic [7:0] OFS_ERR  = 8'h40;
  // field positions in the config word, each NAX bits wide
  localparam int CF_LIMH  = 0;
  localparam int CF_HSINV = 4;
  localparam int CF_HIDX  = 8;
  localparam int CF_HSTOP = 12;
  localparam int CF_SLIP  = 16;
  localparam int CF_STEP  = 20;
  // encoder wiring word
  localparam int EN_AINV  = 0;
  localparam int EN_SWAP  = 4;
  // command word
  localparam int CM_SEEK  = 0;
  localparam int CM_REV   = 4;
  localparam int CM_ABORT = 8;
  // status word
  localparam int ST_OVERTRAVEL_FLAG  = 0;
  localparam int ST_SLIP  = 4;
  localparam int ST_BUSY  = 8;
  localparam int ST_DRV   = 12;
  // reset values
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] ENC_RST  = 32'h0000_0000;
  localparam logic [31:0] HVAL_RST = 32'h0000_0000;
  localparam logic [31:0] SLIP_RST = 32'h0000_0100;
  localparam logic [7:0]  GAIN_RST = 8'h10;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_DEC = 2'h3;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SEEK = 2'b01,
    HS_HALT = 2'b10
  } aehl_home_st_t;
endpackage
`default_nettype wire

// ===== bench/aehl_enc_model.sv
// quadrature encoder and index model for four axes
`default_nettype none
module aehl_enc_model
(
  // clock
  input  wire logic       aclk,
  // step control, one bit per axis
  input  wire logic [3:0] stp,
  input  wire logic [3:0] fwd,
  input  wire logic [3:0] jump,
  input  wire logic [3:0] idx_on,
  // encoder lines
  output logic      [3:0] enc_a,
  output logic      [3:0] enc_b,
  output logic      [3:0] enc_idx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] k_r [4];
  initial k_r = '{default: 2'h0};
  // jump makes both phases change at once, which is illegal
  always @(posedge aclk)
    for (int i = 0; i < 4; i++)
      if (jump[i]) k_r[i] <= k_r[i] + 2'h2;
      else if (stp[i]) k_r[i] <= fwd[i] ? k_r[i] + 2'h1 : k_r[i] - 2'h1;
  always_comb
    for (int i = 0; i < 4; i++)
    begin
      enc_a[i]   = k_r[i][0] ^ k_r[i][1]; // a leads b forward
      enc_b[i]   = k_r[i][1];
      // index wider than quadrant 11 so the quadrant gate matters
      enc_idx[i] = idx_on[i] & (enc_a[i] | enc_b[i]);
    end
endmodule // aehl_enc_model
`default_nettype wire

// ===== bench/aehl_axis_test.sv
// self-checking bench for the axis encoder, home and limit block
`default_nettype none
module aehl_axis_test;
  import aehl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GAP = ENC_MIN_CYC;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, d;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
  logic        arvalid = 1'b0, rready = 1'b0, clr = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  stp = 4'h0, fwd = 4'hF, jump = 4'h0, idx_on = 4'h0;
  logic [3:0]  limit_in = 4'hF, home_sw = 4'hF, move_done = 4'h0;
  logic [3:0]  sd = 4'h0, ss = 4'h0;
  logic [3:0]  enc_a, enc_b, enc_idx, drive_en, seek_run, seek_dir;
  logic [3:0]  decel_req, stop_now, corr_req, corr_dir;
  logic [63:0] servo_out;
  int          n_fail = 0;
  int          check_count = 0;
  always #20 aclk = ~aclk;
  // sticky capture of the one-cycle stop pulses
  always @(posedge aclk)
  begin
    sd <= clr ? 4'h0 : sd | decel_req;
    ss <= clr ? 4'h0 : ss | stop_now;
  end
  aehl_enc_model aehl_enc_model_i (.aclk(aclk), .stp(stp), .fwd(fwd), .jump(jump),
    .idx_on(idx_on), .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx));
  aehl_axis aehl_axis_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .enc_a(enc_a), .enc_b(enc_b),
    .enc_idx(enc_idx), .limit_in(limit_in), .home_sw(home_sw),
    .move_done(move_done), .drive_en(drive_en), .seek_run(seek_run),
    .seek_dir(seek_dir), .decel_req(decel_req), .stop_now(stop_now),
    .corr_req(corr_req), .corr_dir(corr_dir), .servo_out(servo_out));
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 300)
    begin
      n_fail++;
      $display("mismatch at %0t: no answer", $time);
      conclude;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chkr(input logic [1:0] exp, input string m);
    check_count++;
    if (resp !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s resp %h", $time, m, resp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int   n;
    logic aw_dn, w_dn;
    n = 0;
    aw_dn = 1'b0;
    w_dn = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // bready stays high, so the answer is taken at the edge it is seen
    do
    begin
      tick(n);
      if (!aw_dn && awready)
      begin
        aw_dn = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_dn && wready)
      begin
        w_dn = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1);
    resp = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do tick(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do tick(n); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    rd(a);
    chk(d, e, m);
  endtask
  // steps spaced GAP cycles keep the edge rate just under the 4 MHz ceiling
  task automatic steps(input int ax, input int cnt, input logic dir);
    fwd[ax] <= dir;
    repeat (cnt)
    begin
      stp[ax] <= 1'b1;
      @(posedge aclk);
      stp[ax] <= 1'b0;
      repeat (GAP - 1) @(posedge aclk);
    end
  endtask
  task automatic clrs;
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
  endtask
  task automatic wait_seen(input int ax);
    int n;
    n = 0;
    do tick(n); while (!(sd[ax] | ss[ax]));
  endtask
  task automatic t_reset;
    rdc(OFS_CFG, CFG_RST, "cfg");
    rdc(OFS_ENC, ENC_RST, "enc");
    rdc(OFS_HVAL, HVAL_RST, "hval");
    rdc(OFS_SLIP, SLIP_RST, "slip");
    rdc(OFS_GAIN, {24'h0, GAIN_RST}, "gain");
    rdc(OFS_STAT, 32'h0000_F000, "stat");
    wr(OFS_POS, 32'h0000_00AA);
    rdc(OFS_POS, 32'h0, "count read-only");
    rdc(OFS_CMD, 32'h0, "cmd write-only");
    rd(8'h1C);
    chkr(RESP_DEC, "rd unmapped");
    wr(8'h50, 32'h1);
    chkr(RESP_DEC, "wr unmapped");
    $display("test reset finished");
  endtask
  task automatic t_limit;
    limit_in[1] <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({28'h0, drive_en}, 32'hD, "one axis off");
    rd(OFS_STAT);
    chk(d & 32'hF00F, 32'hD002, "overtravel");
    wr(OFS_CFG, 32'h2);
    chk({28'h0, drive_en}, 32'hF, "low now idle");
    limit_in[1] <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({28'h0, drive_en}, 32'hD, "high active");
    wr(OFS_CFG, 32'h0);
    wr(OFS_STAT, 32'hFF);
    rd(OFS_STAT);
    chk(d & 32'hFF, 32'h0, "flags cleared");
    $display("test limit finished");
  endtask
  task automatic t_enc;
    steps(0, 8, 1'b1);
    rdc(OFS_POS, 32'h8, "fwd count");
    steps(0, 4, 1'b0);
    jump[0] <= 1'b1;
    @(posedge aclk);
    jump[0] <= 1'b0;
    rdc(OFS_POS, 32'h4, "rev, illegal");
    wr(OFS_ENC, 32'h1 << EN_SWAP);
    steps(0, 6, 1'b1);
    wr(OFS_ENC, 32'h0);
    rdc(OFS_POS, 32'hFFFF_FFFE, "swapped");
    $display("test encoder finished");
  endtask
  task automatic t_home;
    wr(OFS_HVAL, 32'h0000_1234);
    wr(OFS_CMD, 32'h1 << (CM_SEEK + 2));
    @(posedge aclk);
    chk({28'h0, seek_run & seek_dir}, 32'h4, "seek fwd");
    clrs;
    home_sw[2] <= 1'b0;
    wait_seen(2);
    chk({24'h0, ss, sd}, 32'h04, "decel");
    chk({28'h0, seek_run}, 32'h0, "seek over");
    rdc(OFS_POS + 8'h8, 32'h0000_1234, "home load");
    wr(OFS_CFG, 32'h0000_4040);
    wr(OFS_HVAL, 32'h0000_0055);
    wr(OFS_CMD, 32'h1 << (CM_REV + 2));
    @(posedge aclk);
    chk({28'h0, seek_run & ~seek_dir}, 32'h4, "seek rev");
    clrs;
    repeat (10) @(posedge aclk);
    chk({28'h0, sd | ss}, 32'h0, "closed idle");
    home_sw[2] <= 1'b1;
    wait_seen(2);
    chk({24'h0, ss, sd}, 32'h40, "stop now");
    rdc(OFS_POS + 8'h8, 32'h0000_0055, "inv load");
    wr(OFS_CFG, 32'h0);
    $display("test home finished");
  endtask
  task automatic t_index;
    wr(OFS_CFG, 32'h1 << (CF_HIDX + 3) | 32'h1 << (CF_HSINV + 3));
    wr(OFS_HVAL, 32'h0000_0777);
    idx_on[3] <= 1'b1;
    wr(OFS_CMD, 32'h1 << (CM_SEEK + 3));
    clrs;
    steps(3, 8, 1'b1);
    chk({28'h0, sd | ss}, 32'h0, "open ignored");
    home_sw[3] <= 1'b0; // closed under one revolution
    for (int i = 0; i < 8 && !(sd[3] | ss[3]); i++)
      steps(3, 1, 1'b1);
    chk({29'h0, sd[3] | ss[3], enc_a[3], enc_b[3]}, 32'h7, "quadrant");
    rdc(OFS_POS + 8'hC, 32'h0000_0777, "index load");
    home_sw[3] <= 1'b1;
    idx_on[3] <= 1'b0;
    wr(OFS_CFG, 32'h0);
    $display("test index finished");
  endtask
  task automatic t_servo;
    wr(OFS_TGT, 32'h0000_01FE);
    rdc(OFS_ERR, 32'h0000_0200, "error");
    chk({16'h0, servo_out[15:0]}, 32'h0200, "servo word");
    rd(OFS_STAT);
    chk(d & 32'h10, 32'h0, "slip unarmed");
    wr(OFS_CFG, 32'h1 << CF_SLIP);
    rd(OFS_STAT);
    chk(d & 32'h10, 32'h10, "slip armed");
    wr(OFS_CFG, 32'h1 << CF_SLIP | 32'h1 << CF_STEP);
    move_done[0] <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({30'h0, corr_req[0], corr_dir[0]}, 32'h3, "correct");
    chk({16'h0, servo_out[15:0]}, 32'h0, "stepper quiet");
    move_done[0] <= 1'b0;
    $display("test servo finished");
  endtask
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_limit;
    t_enc;
    t_home;
    t_index;
    t_servo;
    conclude;
  end
  initial
  begin
    #(40 * 20000);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude;
  end
endmodule // aehl_axis_test
`default_nettype wire
